// [hw/ccpbt_code_lut.sv]
// Code to cycle-count table for dead or blank time.
// Purely combinational; caller registers the result via a timer.
`timescale 1ns/1ps
`include "ccpbt_map.svh"
module ccpbt_code_lut
  import ccpbt_pkg::*;
#(
  parameter int CNT_W = 11,
  parameter bit BLANK = 1'b0
) (
  input  wire ccpbt_code_t      code,
  output logic [CNT_W-1:0]      cycles
);
  // Least times, rounded up to whole cycles
  function automatic logic [CNT_W-1:0] lut_cycles(input logic b,
                                                  input ccpbt_code_t c);
    case (c)
      3'h0: lut_cycles = b ? CNT_W'(`CCPBT_CYC(`CCPBT_T625_NS))
                           : CNT_W'(`CCPBT_CYC(`CCPBT_T375_NS));
      3'h1: lut_cycles = b ? CNT_W'(`CCPBT_CYC(`CCPBT_T1000_NS))
                           : CNT_W'(`CCPBT_CYC(`CCPBT_T625_NS));
      3'h2: lut_cycles = b ? CNT_W'(`CCPBT_CYC(`CCPBT_T1250_NS))
                           : CNT_W'(`CCPBT_CYC(`CCPBT_T1000_NS));
      3'h3: lut_cycles = CNT_W'(`CCPBT_CYC(`CCPBT_T1500_NS));
      3'h4: lut_cycles = CNT_W'(`CCPBT_CYC(`CCPBT_T2000_NS));
      3'h5: lut_cycles = CNT_W'(`CCPBT_CYC(`CCPBT_T3000_NS));
      3'h6: lut_cycles = CNT_W'(`CCPBT_CYC(`CCPBT_T4000_NS));
      default: lut_cycles = CNT_W'(`CCPBT_CYC(`CCPBT_T16000_NS));
    endcase
  endfunction : lut_cycles

  // Same table serves both banks
  assign cycles = lut_cycles(BLANK, code); // RULE10 RULE11 RULE12 RULE16
endmodule : ccpbt_code_lut

// [hw/ccpbt_map.svh]
// Offsets, field positions, reset values and timings of the timing bank.
// Assumes a 125 MHz core clock; included by bare name.
// Summary of operation
// RULE1: Active register at offset 0x05, bank 0
// RULE2: Freewheel register at offset 0x05, bank 1
// RULE3: Active register resets to 0x4924
// RULE4: Freewheel register resets to 0x4924
// RULE5: Bit 15 reserved, always reads zero
// RULE6: Active dead codes at 14:12, 8:6, 2:0
// RULE7: Active blank codes at 11:9, 5:3
// RULE8: Freewheel dead codes at 14:12, 8:6, 2:0
// RULE9: Freewheel blank codes at 11:9, 5:3
// RULE10: Active dead code maps 375 ns..16 us
// RULE11: Active blank code maps 625 ns..16 us
// RULE12: Freewheel dead code uses same mapping
// RULE13: Software limits current for 16 us dead
// RULE14: Software limits current for 16 us blank
// RULE15: Per-bridge 2-bit selector picks timing set
// RULE16: Freewheel blank code uses active blank mapping
// RULE17: Dead time keeps both gates off
// RULE18: Overvoltage ignored during blank time
`ifndef CCPBT_MAP_SVH
`define CCPBT_MAP_SVH

`define CCPBT_CLK_NS      8
`define CCPBT_CYC(ns)     ((((ns) + `CCPBT_CLK_NS - 1) / `CCPBT_CLK_NS))
`define CCPBT_T375_NS     375
`define CCPBT_T625_NS     625
`define CCPBT_T1000_NS    1000
`define CCPBT_T1250_NS    1250
`define CCPBT_T1500_NS    1500
`define CCPBT_T2000_NS    2000
`define CCPBT_T3000_NS    3000
`define CCPBT_T4000_NS    4000
`define CCPBT_T16000_NS   16000

`define CCPBT_OFF_SEL     5'h04
`define CCPBT_OFF_SET2    5'h05
`define CCPBT_OFF_STATUS  5'h1e
`define CCPBT_SET2_RST    16'h4924
`define CCPBT_SET2_MASK   16'h7fff
`define CCPBT_SEL_RST     16'h0000
`define CCPBT_SEL_MASK    16'h00ff
`define CCPBT_RSVD_BIT    15

`define CCPBT_F_DEAD1     2:0
`define CCPBT_F_BLANK1    5:3
`define CCPBT_F_DEAD2     8:6
`define CCPBT_F_BLANK2    11:9
`define CCPBT_F_DEAD3     14:12
`define CCPBT_X_BLANK3    2:0
`define CCPBT_X_DEAD4     5:3
`define CCPBT_X_BLANK4    8:6
`define CCPBT_S_FAULT     3:0
`define CCPBT_S_HS        7:4
`define CCPBT_S_LS        11:8
`define CCPBT_S_PAD       4'h0

`endif

// [hw/ccpbt_pkg.sv]
// Types shared by the timing bank and its helpers.
// Constants live in ccpbt_map.svh.
package ccpbt_pkg;
  typedef logic [2:0] ccpbt_code_t;
  // Gray along off -> dead -> on
  typedef enum logic [1:0] {
    CCPBT_ST_OFF  = 2'b00,
    CCPBT_ST_DEAD = 2'b01,
    CCPBT_ST_ON   = 2'b11
  } ccpbt_state_t;
  typedef enum logic [1:0] {
    CCPBT_CMD_OFF  = 2'b00,
    CCPBT_CMD_LS   = 2'b01,
    CCPBT_CMD_HS   = 2'b10,
    CCPBT_CMD_RSVD = 2'b11
  } ccpbt_cmd_t;
endpackage : ccpbt_pkg

// [hw/ccpbt_timer.sv]
// Loadable down counter used for dead and blank windows.
// done is high once the loaded count has run out.
`timescale 1ns/1ps
module ccpbt_timer #(
  parameter int CNT_W = 11
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output logic                  done
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  // Load wins over counting
  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = load_val;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = (cnt_reg == '0);
endmodule : ccpbt_timer

// [hw/ccpbt_top.sv]
// Timing set 2 registers plus per-bridge dead and blank sequencing.
// Assumes a synchronous register port and synchronous bridge inputs.
// Sets 3 and 4 partial codes arrive from a neighbouring bank.
`timescale 1ns/1ps
`include "ccpbt_map.svh"
module ccpbt_top
  import ccpbt_pkg::*;
#(
  parameter int N_HB  = 4,
  parameter int CNT_W = 11
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              bank_sel,
  input  wire logic [4:0]        addr,
  input  wire logic [15:0]       wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [15:0]       rd_data,
  input  wire logic [2*N_HB-1:0] bridge_cmd,
  input  wire logic [N_HB-1:0]   fw_sel,
  input  wire logic [8:0]        act_ext_codes,
  input  wire logic [8:0]        fw_ext_codes,
  input  wire logic [N_HB-1:0]   ds_ov,
  output logic      [N_HB-1:0]   gate_hs,
  output logic      [N_HB-1:0]   gate_ls,
  output logic      [N_HB-1:0]   ds_fault
);

  ////////////////////////////////////////////////////////////////////////
  // Register bank
  logic [15:0] act_reg;
  logic [15:0] act_next;
  logic [15:0] fw_reg;
  logic [15:0] fw_next;
  logic [15:0] sel_reg;
  logic [15:0] sel_next;
  logic [15:0] rd_reg;
  logic [15:0] rd_next;
  logic [15:0] status;
  logic [N_HB-1:0] hs_q;
  logic [N_HB-1:0] ls_q;
  logic [N_HB-1:0] flt_q;

  // Live bridge state, visible to software
  assign status = {`CCPBT_S_PAD, ls_q, hs_q, flt_q};

  // Writes decode by offset, then by bank
  always_comb begin
    act_next = act_reg;
    fw_next  = fw_reg;
    sel_next = sel_reg;
    if (wr_en) begin
      if (addr == `CCPBT_OFF_SEL) begin
        sel_next = wr_data & `CCPBT_SEL_MASK; // RULE15
      end else if (addr == `CCPBT_OFF_SET2) begin
        if (!bank_sel) begin
          act_next = wr_data & `CCPBT_SET2_MASK; // RULE1 RULE5 RULE6 RULE7
        end else begin
          fw_next = wr_data & `CCPBT_SET2_MASK; // RULE2 RULE5 RULE8 RULE9
        end
      end
    end
  end

  // Read data shows only in the cycle after the strobe
  always_comb begin
    rd_next = 16'h0000;
    if (rd_en) begin
      if (addr == `CCPBT_OFF_SEL) begin
        rd_next = sel_reg;
      end else if (addr == `CCPBT_OFF_SET2) begin
        rd_next = bank_sel ? fw_reg : act_reg; // RULE1 RULE2
      end else if (addr == `CCPBT_OFF_STATUS) begin
        rd_next = status;
      end else begin
        rd_next = 16'h0000;
      end
    end
  end

  // Reset values; ce low freezes everything
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_reg <= `CCPBT_SET2_RST; // RULE3
      fw_reg  <= `CCPBT_SET2_RST; // RULE4
      sel_reg <= `CCPBT_SEL_RST;
      rd_reg  <= 16'h0000;
    end else if (ce) begin
      act_reg <= act_next;
      fw_reg  <= fw_next;
      sel_reg <= sel_next;
      rd_reg  <= rd_next;
    end
  end

  assign rd_data  = rd_reg;
  assign gate_hs  = hs_q;
  assign gate_ls  = ls_q;
  assign ds_fault = flt_q;

  // Pick one of four set codes by selector
  function automatic ccpbt_code_t pick_code(input ccpbt_code_t c1,
                                            input ccpbt_code_t c2,
                                            input ccpbt_code_t c3,
                                            input ccpbt_code_t c4,
                                            input logic [1:0] s);
    case (s)
      2'h0: pick_code = c1;
      2'h1: pick_code = c2;
      2'h2: pick_code = c3;
      default: pick_code = c4;
    endcase
  endfunction : pick_code

  ////////////////////////////////////////////////////////////////////////
  // Register assertions
  property p_act_wr;
    @(posedge clk) disable iff (rst)
    (ce && wr_en && addr == `CCPBT_OFF_SET2 && !bank_sel)
      |=> act_reg == ($past(wr_data) & `CCPBT_SET2_MASK);
  endproperty
  a_act_wr: assert property (p_act_wr) // RULE1
    else $error("active set 2 write not stored");

  property p_fw_wr;
    @(posedge clk) disable iff (rst)
    (ce && wr_en && addr == `CCPBT_OFF_SET2 && bank_sel)
      |=> fw_reg == ($past(wr_data) & `CCPBT_SET2_MASK)
          && act_reg == $past(act_reg);
  endproperty
  a_fw_wr: assert property (p_fw_wr) // RULE2
    else $error("freewheel set 2 write wrong bank");

  property p_act_rst;
    @(posedge clk) disable iff (rst)
    $past(rst) |-> act_reg == `CCPBT_SET2_RST;
  endproperty
  a_act_rst: assert property (p_act_rst) // RULE3
    else $error("active set 2 reset value wrong");

  property p_fw_rst;
    @(posedge clk) disable iff (rst)
    $past(rst) |-> fw_reg == `CCPBT_SET2_RST;
  endproperty
  a_fw_rst: assert property (p_fw_rst) // RULE4
    else $error("freewheel set 2 reset value wrong");

  property p_rsvd;
    @(posedge clk) disable iff (rst)
    (ce && rd_en && addr == `CCPBT_OFF_SET2)
      |=> rd_data[`CCPBT_RSVD_BIT] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) // RULE5
    else $error("reserved bit reads one");

  property p_act_rd;
    @(posedge clk) disable iff (rst)
    (ce && rd_en && addr == `CCPBT_OFF_SET2 && !bank_sel)
      |=> rd_data == $past(act_reg) ##1 (!$past(ce) || $past(rd_en)
          || rd_data == 16'h0000);
  endproperty
  a_act_rd: assert property (p_act_rd) // RULE6 RULE7
    else $error("active set 2 readback wrong");

  property p_fw_rd;
    @(posedge clk) disable iff (rst)
    (ce && rd_en && addr == `CCPBT_OFF_SET2 && bank_sel)
      |=> rd_data == $past(fw_reg);
  endproperty
  a_fw_rd: assert property (p_fw_rd) // RULE8 RULE9
    else $error("freewheel set 2 readback wrong");

  property p_sel_wr;
    @(posedge clk) disable iff (rst)
    (ce && wr_en && addr == `CCPBT_OFF_SEL)
      |=> sel_reg == ($past(wr_data) & `CCPBT_SEL_MASK);
  endproperty
  a_sel_wr: assert property (p_sel_wr) // RULE15
    else $error("set selector write not stored");

  ////////////////////////////////////////////////////////////////////////
  // Per-bridge sequencing
  genvar b;
  generate
    for (b = 0; b < N_HB; b++) begin : g_hb
      ccpbt_state_t     st_reg;
      ccpbt_state_t     st_next;
      ccpbt_cmd_t       cmd;
      logic [1:0]       tgt_reg;
      logic [1:0]       tgt_next;
      logic             hs_reg;
      logic             hs_next;
      logic             ls_reg;
      logic             ls_next;
      logic             flt_reg;
      logic             flt_next;
      logic             cmd_on;
      logic             dead_load;
      logic             blank_load;
      logic             dead_done;
      logic             blank_done;
      logic [1:0]       sel;
      ccpbt_code_t      act_dead;
      ccpbt_code_t      act_blank;
      ccpbt_code_t      fw_dead;
      ccpbt_code_t      fw_blank;
      ccpbt_code_t      dead_code;
      ccpbt_code_t      blank_code;
      logic [CNT_W-1:0] dead_cyc;
      logic [CNT_W-1:0] blank_cyc;
      logic [CNT_W:0]   off_cnt_reg;
      logic [CNT_W-1:0] dead_len_reg;

      assign cmd = ccpbt_cmd_t'(bridge_cmd[2*b +: 2]);
      assign sel = sel_reg[2*b +: 2];

      // Bridge picks its own set
      assign act_dead  = pick_code(act_reg[`CCPBT_F_DEAD1],
                                   act_reg[`CCPBT_F_DEAD2],
                                   act_reg[`CCPBT_F_DEAD3],
                                   act_ext_codes[`CCPBT_X_DEAD4],
                                   sel); // RULE15 RULE6
      assign act_blank = pick_code(act_reg[`CCPBT_F_BLANK1],
                                   act_reg[`CCPBT_F_BLANK2],
                                   act_ext_codes[`CCPBT_X_BLANK3],
                                   act_ext_codes[`CCPBT_X_BLANK4],
                                   sel); // RULE15 RULE7
      assign fw_dead   = pick_code(fw_reg[`CCPBT_F_DEAD1],
                                   fw_reg[`CCPBT_F_DEAD2],
                                   fw_reg[`CCPBT_F_DEAD3],
                                   fw_ext_codes[`CCPBT_X_DEAD4],
                                   sel); // RULE15 RULE8
      assign fw_blank  = pick_code(fw_reg[`CCPBT_F_BLANK1],
                                   fw_reg[`CCPBT_F_BLANK2],
                                   fw_ext_codes[`CCPBT_X_BLANK3],
                                   fw_ext_codes[`CCPBT_X_BLANK4],
                                   sel); // RULE15 RULE9

      // Bank follows the bridge's fw_sel bit
      assign dead_code  = fw_sel[b] ? fw_dead : act_dead; // RULE1 RULE2
      assign blank_code = fw_sel[b] ? fw_blank : act_blank;

      ccpbt_code_lut #(.CNT_W(CNT_W), .BLANK(1'b0)) u_dead_lut (
        .code   (dead_code),
        .cycles (dead_cyc)
      );
      ccpbt_code_lut #(.CNT_W(CNT_W), .BLANK(1'b1)) u_blank_lut (
        .code   (blank_code),
        .cycles (blank_cyc)
      );
      ccpbt_timer #(.CNT_W(CNT_W)) u_dead_tmr (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .load     (dead_load),
        .load_val (dead_cyc),
        .done     (dead_done)
      );
      ccpbt_timer #(.CNT_W(CNT_W)) u_blank_tmr (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .load     (blank_load),
        .load_val (blank_cyc),
        .done     (blank_done)
      );

      // Reserved command code counts as off
      assign cmd_on = (cmd == CCPBT_CMD_LS) || (cmd == CCPBT_CMD_HS);

      // Every turn-on passes through a dead window first
      always_comb begin
        st_next    = st_reg;
        tgt_next   = tgt_reg;
        dead_load  = 1'b0;
        blank_load = 1'b0;
        case (st_reg)
          CCPBT_ST_OFF: begin
            if (cmd_on) begin
              st_next   = CCPBT_ST_DEAD;
              tgt_next  = cmd;
              dead_load = 1'b1; // RULE17
            end
          end
          CCPBT_ST_DEAD: begin
            if (!cmd_on) begin
              st_next = CCPBT_ST_OFF;
            end else if (cmd != tgt_reg) begin
              tgt_next  = cmd;
              dead_load = 1'b1; // RULE17
            end else if (dead_done) begin
              st_next    = CCPBT_ST_ON;
              blank_load = 1'b1; // RULE18
            end
          end
          CCPBT_ST_ON: begin
            if (!cmd_on) begin
              st_next = CCPBT_ST_OFF;
            end else if (cmd != tgt_reg) begin
              st_next   = CCPBT_ST_DEAD;
              tgt_next  = cmd;
              dead_load = 1'b1; // RULE17
            end
          end
          default: st_next = CCPBT_ST_OFF;
        endcase
        // Gates high only in ON, so never both at once
        hs_next = (st_next == CCPBT_ST_ON) && (tgt_next == CCPBT_CMD_HS);
        ls_next = (st_next == CCPBT_ST_ON) && (tgt_next == CCPBT_CMD_LS);
        // Overvoltage counts only after the blank window
        flt_next = (st_reg == CCPBT_ST_ON) && (st_next == CCPBT_ST_ON)
                   && blank_done && ds_ov[b]; // RULE18
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          st_reg  <= CCPBT_ST_OFF;
          tgt_reg <= CCPBT_CMD_OFF;
          hs_reg  <= 1'b0;
          ls_reg  <= 1'b0;
          flt_reg <= 1'b0;
        end else if (ce) begin
          st_reg  <= st_next;
          tgt_reg <= tgt_next;
          hs_reg  <= hs_next;
          ls_reg  <= ls_next;
          flt_reg <= flt_next;
        end
      end

      assign hs_q[b]  = hs_reg;
      assign ls_q[b]  = ls_reg;
      assign flt_q[b] = flt_reg;

      // Watch logic: off span and armed dead length
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          off_cnt_reg  <= '0;
          dead_len_reg <= '0;
        end else if (ce) begin
          if (hs_reg || ls_reg) begin
            off_cnt_reg <= '0;
          end else if (!(&off_cnt_reg)) begin
            off_cnt_reg <= off_cnt_reg + (CNT_W+1)'(1);
          end
          if (dead_load) begin
            dead_len_reg <= dead_cyc;
          end
        end
      end

      property p_dead;
        @(posedge clk) disable iff (rst)
        $rose(hs_reg || ls_reg)
          |-> $past(off_cnt_reg) >= {1'b0, $past(dead_len_reg)};
      endproperty
      a_dead: assert property (p_dead) // RULE17 RULE10 RULE12
        else $error("gate turned on before dead time ran out");

      property p_excl;
        @(posedge clk) disable iff (rst)
        !(hs_reg && ls_reg) && (hs_reg == (st_reg == CCPBT_ST_ON
          && tgt_reg == CCPBT_CMD_HS));
      endproperty
      a_excl: assert property (p_excl) // RULE17
        else $error("gate pair overlap or stray gate");

      property p_blank;
        @(posedge clk) disable iff (rst)
        $rose(flt_reg)
          |-> $past(blank_done) && $past(ds_ov[b]) && (hs_reg || ls_reg);
      endproperty
      a_blank: assert property (p_blank) // RULE18 RULE11 RULE16
        else $error("overvoltage flagged inside blank window");

      property p_blank_first;
        @(posedge clk) disable iff (rst)
        (ce && blank_load) |=> !flt_reg;
      endproperty
      a_blank_first: assert property (p_blank_first) // RULE18
        else $error("fault raised at gate turn-on");
    end
  endgenerate

endmodule : ccpbt_top

// [sim/ccpbt_host.sv]
// Host side of the timing bank: drives the register port.
// Assumes tasks are entered just after a rising edge of clk.
`timescale 1ns/1ps
module ccpbt_host (
  input  wire logic        clk,
  output logic             bank_sel,
  output logic [4:0]       addr,
  output logic [15:0]      wr_data,
  output logic             wr_en,
  output logic             rd_en
);
  // Quiet bus at time zero
  initial begin
    bank_sel = 1'b0;
    addr     = 5'h00;
    wr_data  = 16'h0000;
    wr_en    = 1'b0;
    rd_en    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle write; code 111 only with drive current limited elsewhere
  task automatic wr(input logic b, input logic [4:0] a,
                    input logic [15:0] d);
    bank_sel <= b;
    addr     <= a;
    wr_data  <= d;
    wr_en    <= 1'b1;
    rd_en    <= 1'b0;
    @(posedge clk);
  endtask : wr

  // One-cycle read; data lands in the following cycle
  task automatic rd(input logic b, input logic [4:0] a);
    bank_sel <= b;
    addr     <= a;
    wr_data  <= ~wr_data;
    wr_en    <= 1'b0;
    rd_en    <= 1'b1;
    @(posedge clk);
  endtask : rd

  // Released bus keeps toggling so stale values never look valid
  task automatic idle();
    bank_sel <= ~bank_sel;
    addr     <= ~addr;
    wr_data  <= ~wr_data;
    wr_en    <= 1'b0;
    rd_en    <= 1'b0;
    @(posedge clk);
  endtask : idle
endmodule : ccpbt_host

// [sim/ccpbt_tb_top.sv]
// Self-checking bench for the timing bank and bridge sequencing.
// Assumes design constants from ccpbt_map.svh, 125 MHz clock.
`timescale 1ns/1ps
module ccpbt_tb_top;
  logic        clk;
  logic        rst;
  logic        ce;
  logic        bank_sel;
  logic [4:0]  addr;
  logic [15:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [15:0] rd_data;
  logic [7:0]  bridge_cmd;
  logic [3:0]  fw_sel;
  logic [8:0]  act_ext_codes;
  logic [8:0]  fw_ext_codes;
  logic [3:0]  ds_ov;
  logic [3:0]  gate_hs;
  logic [3:0]  gate_ls;
  logic [3:0]  ds_fault;
  int          errors;
  int          n_checks;
  int          seed;
  int          t_cnt;
  logic        rd_seen;
  logic        pg;
  logic        pf;
  logic [1:0]  pc;
  logic [15:0] rq[$];
  logic [15:0] tq[$];
  logic [15:0] model[2];
  int          dead_ns[8]  = '{375, 625, 1000, 1500, 2000, 3000, 4000, 16000};
  int          blank_ns[8] = '{625, 1000, 1250, 1500, 2000, 3000, 4000, 16000};

  ccpbt_host u_ccpbt_host (
    .clk(clk), .bank_sel(bank_sel), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en));

  ccpbt_top u_ccpbt_top (
    .clk(clk), .rst(rst), .ce(ce), .bank_sel(bank_sel), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .bridge_cmd(bridge_cmd), .fw_sel(fw_sel),
    .act_ext_codes(act_ext_codes), .fw_ext_codes(fw_ext_codes),
    .ds_ov(ds_ov), .gate_hs(gate_hs), .gate_ls(gate_ls),
    .ds_fault(ds_fault));

  ////////////////////////////////////////////////////////////////////////////
  // 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Single compare point
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Read with the expected word noted first
  task automatic rd_exp(input logic b, input logic [4:0] a,
                        input logic [15:0] e);
    rq.push_back(e);
    u_ccpbt_host.rd(b, a);
  endtask : rd_exp

  // Write while tracking the bank model
  task automatic wr_m(input logic b, input logic [15:0] d);
    model[b] = d & 16'h7fff;
    u_ccpbt_host.wr(b, 5'h05, d);
  endtask : wr_m

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: read data and bridge timing, sampled mid-cycle
  always @(posedge clk) rd_seen <= rd_en;
  always @(negedge clk) begin
    if (rd_seen)
      check(rd_data, rq.pop_front());
    // Count restarts when bridge 0 is asked to turn on from off
    if ((pc == 2'b00 || pc == 2'b11) && (bridge_cmd[1:0] == 2'b01
        || bridge_cmd[1:0] == 2'b10))
      t_cnt = 0;
    else
      t_cnt++;
    if ((gate_hs[0] | gate_ls[0]) === 1'b1 && pg !== 1'b1)
      check(t_cnt[15:0], tq.pop_front());
    if (ds_fault[0] === 1'b1 && pf !== 1'b1)
      check(t_cnt[15:0], tq.pop_front());
    pg = gate_hs[0] | gate_ls[0];
    pf = ds_fault[0];
    pc = bridge_cmd[1:0];
  end

  // Hang guard, well above the longest sequence
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin : main
    logic [15:0] w;
    logic [2:0]  o;
    int          sel;
    int          nd;
    int          nb;
    logic        fb;
    logic [5:0]  x;
    errors = 0;
    n_checks = 0;
    seed = 40;
    t_cnt = 0;
    rd_seen = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    bridge_cmd = 8'h00;
    fw_sel = 4'h0;
    ds_ov = 4'h0;
    act_ext_codes = 9'h000;
    fw_ext_codes = 9'h000;
    model[0] = 16'h4924;
    model[1] = 16'h4924;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset words, back to back reads
    rd_exp(1'b0, 5'h05, 16'h4924);
    rd_exp(1'b1, 5'h05, 16'h4924);
    rd_exp(1'b0, 5'h04, 16'h0000);
    // Frozen clock enable must swallow a write
    ce <= 1'b0;
    u_ccpbt_host.wr(1'b0, 5'h05, 16'h0000);
    ce <= 1'b1;
    rd_exp(1'b0, 5'h05, 16'h4924);
    // All ones, reserved bit drops, other bank untouched
    wr_m(1'b0, 16'hffff);
    rd_exp(1'b0, 5'h05, 16'h7fff);
    rd_exp(1'b1, 5'h05, 16'h4924);
    // Random words into random banks, plus an unmapped place
    repeat (8) begin
      fb = 1'($random(seed));
      w = 16'($random(seed));
      wr_m(fb, w);
      rd_exp(fb, 5'h05, model[fb]);
      u_ccpbt_host.wr(fb, 5'h10, ~w);
      rd_exp(fb, 5'h10, 16'h0000);
      rd_exp(~fb, 5'h05, model[~fb]);
    end
    u_ccpbt_host.idle();
    // Every code through dead and blank, rotating bank and set
    for (int i = 0; i < 8; i++) begin
      sel = i % 4;
      fb = i[0];
      o = 3'(i + 3);
      w = {1'b0, o, o, o, o, o};
      case (sel)
        0: w[5:0] = {3'(i), 3'(i)};
        1: w[11:6] = {3'(i), 3'(i)};
        2: w[14:12] = 3'(i);
        default: ;
      endcase
      wr_m(fb, w);
      wr_m(~fb, {1'b0, o, o, o, o, o});
      u_ccpbt_host.wr(1'b0, 5'h04, 16'(sel));
      u_ccpbt_host.idle();
      // Set 4 lives on the side inputs, so it carries the code there
      x = (sel == 3) ? {3'(i), 3'(i)} : 6'($random(seed));
      act_ext_codes <= {x, 3'(i)};
      fw_ext_codes <= {x, 3'(i)};
      fw_sel <= {3'($random(seed)), fb};
      ds_ov <= {3'($random(seed)), 1'b1};
      nd = (dead_ns[i] + 7) / 8;
      nb = (blank_ns[i] + 7) / 8;
      tq.push_back(16'(nd + 2));
      tq.push_back(16'(nd + nb + 3));
      bridge_cmd <= i[1] ? 8'h01 : 8'h02;
      repeat (nd + nb + 6) @(posedge clk);
      rd_exp(fb, 5'h05, model[fb]);
      rd_exp(1'b0, 5'h1e, i[1] ? 16'h0101 : 16'h0011);
      u_ccpbt_host.idle();
      // Reserved code must drop the gate like plain off
      bridge_cmd <= i[0] ? 8'h03 : 8'h00;
      ds_ov <= 4'h0;
      repeat (2) @(posedge clk);
      rd_exp(1'b0, 5'h1e, 16'h0000);
      u_ccpbt_host.idle();
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    if (tq.size() != 0 || rq.size() != 0)
      errors++;
    complete_run();
  end
endmodule : ccpbt_tb_top
